// >>> dlgc_defines.svh
// Register offsets, field positions and reset values of the demodulator loop gain registers.
`ifndef DLGC_DEFINES_SVH
`define DLGC_DEFINES_SVH

// ==========================================================================
// Register offsets
`define DLGC_FREQ_OFFSET_COMP_CFG_ADDR 6'h19
`define DLGC_BIT_SYNC_CFG_ADDR 6'h1A

// ==========================================================================
// Frequency offset configuration fields
`define DLGC_FOC_GATE_BIT 5
`define DLGC_FOC_PRE_HI 4
`define DLGC_FOC_PRE_LO 3
`define DLGC_FOC_POST_BIT 2
`define DLGC_FOC_LIM_HI 1
`define DLGC_FOC_LIM_LO 0
`define DLGC_FOC_WR_MASK 8'h3F
`define DLGC_FOC_RESET 8'h36

// ==========================================================================
// Bit synchronisation configuration fields
`define DLGC_BS_KI_HI 7
`define DLGC_BS_KI_LO 6
`define DLGC_BS_KP_HI 5
`define DLGC_BS_KP_LO 4
`define DLGC_CLK_INTEGRAL_GAIN_POST_SYNC_BIT 3
`define DLGC_CLK_PROP_GAIN_POST_SYNC_BIT 2
`define DLGC_BS_LIM_HI 1
`define DLGC_BS_LIM_LO 0
`define DLGC_BS_RESET 8'h6C

// ==========================================================================
// Reset values of the registered loop controls
`define DLGC_FREQ_GAIN_RESET 4'h6
`define DLGC_KI_GAIN_RESET 4'h4
`define DLGC_KP_GAIN_RESET 4'h6
`define DLGC_FOC_LIM_RESET 2'h2
`define DLGC_BS_LIM_RESET 2'h0

`endif

// >>> dlgc_pkg.sv
// Types shared by the demodulator loop gain configuration block.
package dlgc_pkg;

    // Gain applied by a loop, in half steps of its base gain K (1 = K/2, 2 = K, ... 8 = 4K).
    typedef logic [3:0] dlgc_gain_t;

    // Saturation code kept as a two-bit selector.
    typedef logic [1:0] dlgc_sel_t;

    // Phase of the current reception.
    typedef enum logic [1:0] {
        DLGC_IDLE,
        DLGC_WAIT_CS,
        DLGC_PRE_SYNC,
        DLGC_POST_SYNC
    } dlgc_phase_e;

endpackage : dlgc_pkg

// >>> dlgc_gain_sel.sv
// Gain selector: picks the pre-sync or post-sync gain of one loop.
`timescale 1ns/1ps

module dlgc_gain_sel
    import dlgc_pkg::*;
(
    input wire logic [1:0] pre_code,
    input wire logic post_bit,
    input wire logic post_halves,
    input wire logic after_sync,
    output dlgc_gain_t gain
);

    // Pre-sync code n selects (n+1)K, expressed here in half steps.
    function automatic dlgc_gain_t pre_gain(input logic [1:0] code);
        // Widen before adding so that code 3 reaches 8 instead of wrapping to 0.
        pre_gain = dlgc_gain_t'({code, 1'b0}) + 4'h2;
    endfunction : pre_gain

    always_comb begin
        if (after_sync && post_bit) begin
            // A set post-sync bit either halves the base gain or keeps the base gain.
            gain = post_halves ? 4'h1 : 4'h2;
        end else begin
            gain = pre_gain(pre_code);
        end
    end

endmodule : dlgc_gain_sel

// >>> dlgc_loop_cfg.sv
// Register bank steering the demodulator frequency and clock recovery loops.
`timescale 1ns/1ps
`include "dlgc_defines.svh"

// Function
// - Gate bit set freezes both loops until carrier sense goes high.
// - Pre-sync frequency gain is (code+1)K from bits 4:3, reset 10.
// - Post-sync frequency gain: bit 2 clear keeps pre gain, set gives K/2.
// - Frequency saturation bits 1:0: zero, BW/8, BW/4, BW/2.
// - Pre-sync clock integral gain is (code+1)KI from bits 7:6, reset 01.
// - Pre-sync clock proportional gain is (code+1)KP from bits 5:4, reset 10.
// - Post-sync integral gain: bit 3 clear keeps pre gain, set gives KI/2.
// - Post-sync proportional gain: bit 2 clear keeps pre gain, set gives KP.
// - Rate saturation bits 1:0: none, 3.125, 6.25, 12.5 percent.
// - Frequency register bits 7:6 read zero and ignore writes.
module dlgc_loop_cfg
    import dlgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic rx_active,
    input wire logic carrier_sense,
    input wire logic sync_detected,
    output logic freq_loop_freeze,
    output logic clk_loop_freeze,
    output dlgc_gain_t freq_loop_gain,
    output dlgc_gain_t clk_integral_gain,
    output dlgc_gain_t clk_prop_gain,
    output dlgc_sel_t freq_offset_saturation,
    output dlgc_sel_t rate_offset_saturation
);

    // ======================================================================
    // Registers
    logic [7:0] freq_offset_comp_cfg_q;
    logic [7:0] bit_sync_cfg_q;
    dlgc_phase_e phase_q;
    dlgc_phase_e phase_d;
    logic after_sync;
    logic freeze;
    dlgc_gain_t freq_gain_c;
    dlgc_gain_t ki_gain_c;
    dlgc_gain_t kp_gain_c;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_offset_comp_cfg_q <= `DLGC_FOC_RESET;
        end else if (reg_wr_en && reg_addr == `DLGC_FREQ_OFFSET_COMP_CFG_ADDR) begin
            freq_offset_comp_cfg_q <= reg_wr_data & `DLGC_FOC_WR_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bit_sync_cfg_q <= `DLGC_BS_RESET;
        end else if (reg_wr_en && reg_addr == `DLGC_BIT_SYNC_CFG_ADDR) begin
            bit_sync_cfg_q <= reg_wr_data;
        end
    end

    // Reads of any other address return zero.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `DLGC_FREQ_OFFSET_COMP_CFG_ADDR: reg_rd_data <= freq_offset_comp_cfg_q;
                `DLGC_BIT_SYNC_CFG_ADDR: reg_rd_data <= bit_sync_cfg_q;
                default: reg_rd_data <= 8'h00;
            endcase
        end
    end

    // ======================================================================
    // Reception phase
    // The control inputs come from demodulator logic on this clock, so no
    // synchroniser is placed on them.
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            DLGC_IDLE: begin
                if (rx_active) begin
                    phase_d = (freq_offset_comp_cfg_q[`DLGC_FOC_GATE_BIT] && !carrier_sense)
                        ? DLGC_WAIT_CS : DLGC_PRE_SYNC;
                end
            end
            DLGC_WAIT_CS: begin
                if (carrier_sense) begin
                    phase_d = DLGC_PRE_SYNC;
                end
            end
            DLGC_PRE_SYNC: begin
                if (sync_detected) begin
                    phase_d = DLGC_POST_SYNC;
                end
            end
            DLGC_POST_SYNC: begin
                phase_d = DLGC_POST_SYNC;
            end
        endcase
        if (!rx_active) begin
            phase_d = DLGC_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_q <= DLGC_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign after_sync = (phase_d == DLGC_POST_SYNC);
    assign freeze = (phase_d == DLGC_WAIT_CS);

    // ======================================================================
    // Gain selection
    dlgc_gain_sel u_freq_gain (
        .pre_code(freq_offset_comp_cfg_q[`DLGC_FOC_PRE_HI:`DLGC_FOC_PRE_LO]),
        .post_bit(freq_offset_comp_cfg_q[`DLGC_FOC_POST_BIT]),
        .post_halves(1'b1),
        .after_sync(after_sync),
        .gain(freq_gain_c)
    );

    dlgc_gain_sel u_ki_gain (
        .pre_code(bit_sync_cfg_q[`DLGC_BS_KI_HI:`DLGC_BS_KI_LO]),
        .post_bit(bit_sync_cfg_q[`DLGC_CLK_INTEGRAL_GAIN_POST_SYNC_BIT]),
        .post_halves(1'b1),
        .after_sync(after_sync),
        .gain(ki_gain_c)
    );

    // A set post-sync proportional bit drops to the base gain KP, not half.
    dlgc_gain_sel u_kp_gain (
        .pre_code(bit_sync_cfg_q[`DLGC_BS_KP_HI:`DLGC_BS_KP_LO]),
        .post_bit(bit_sync_cfg_q[`DLGC_CLK_PROP_GAIN_POST_SYNC_BIT]),
        .post_halves(1'b0),
        .after_sync(after_sync),
        .gain(kp_gain_c)
    );

    // ======================================================================
    // Registered loop controls
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_loop_freeze <= 1'b0;
            clk_loop_freeze <= 1'b0;
        end else begin
            freq_loop_freeze <= freeze;
            clk_loop_freeze <= freeze;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_loop_gain <= `DLGC_FREQ_GAIN_RESET;
            clk_integral_gain <= `DLGC_KI_GAIN_RESET;
            clk_prop_gain <= `DLGC_KP_GAIN_RESET;
        end else begin
            freq_loop_gain <= freq_gain_c;
            clk_integral_gain <= ki_gain_c;
            clk_prop_gain <= kp_gain_c;
        end
    end

    // Saturation codes pass unchanged; an on-off keying user must write zero here.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_offset_saturation <= `DLGC_FOC_LIM_RESET;
            rate_offset_saturation <= `DLGC_BS_LIM_RESET;
        end else begin
            freq_offset_saturation <=
                freq_offset_comp_cfg_q[`DLGC_FOC_LIM_HI:`DLGC_FOC_LIM_LO];
            rate_offset_saturation <= bit_sync_cfg_q[`DLGC_BS_LIM_HI:`DLGC_BS_LIM_LO];
        end
    end

endmodule : dlgc_loop_cfg

// >>> dlgc_loop_cfg_assertions.sv
// Port checker for the demodulator loop gain register bank.
`timescale 1ns/1ps

module dlgc_loop_cfg_chk
    import dlgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic rx_active,
    input wire logic carrier_sense,
    input wire logic sync_detected,
    input wire logic freq_loop_freeze,
    input wire logic clk_loop_freeze,
    input wire dlgc_gain_t freq_loop_gain,
    input wire dlgc_gain_t clk_integral_gain,
    input wire dlgc_gain_t clk_prop_gain,
    input wire dlgc_sel_t freq_offset_saturation,
    input wire dlgc_sel_t rate_offset_saturation
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ==========================================================================
    // Loop controls
    a_freeze_pair: assert property (freq_loop_freeze == clk_loop_freeze)
        else $error("freeze outputs disagree");
    a_freeze_cause: assert property ($rose(freq_loop_freeze) |->
        $past(rx_active) && !$past(carrier_sense)) else $error("freeze without cause");
    a_freeze_release: assert property (freq_loop_freeze && carrier_sense |=>
        !freq_loop_freeze) else $error("freeze outlived carrier");
    // Three idle samples cover the gain register stage, which is fed from the unregistered next phase.
    a_idle_pre_gain: assert property (!rx_active [*3] |-> !freq_loop_gain[0] &&
        !clk_integral_gain[0] && !freq_loop_freeze) else $error("idle gain not pre-sync");
    a_freq_gain_set: assert property (freq_loop_gain inside {1, 2, 4, 6, 8})
        else $error("freq gain off scale");
    a_post_after_sync: assert property ($rose(freq_loop_gain == 4'h1) |->
        $past(sync_detected)) else $error("half gain without sync");

    // ==========================================================================
    // Register reads
    a_rd_unmapped: assert property (reg_rd_en && !(reg_addr inside {6'h19, 6'h1A})
        |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
    a_rd_top_zero: assert property (reg_rd_en && reg_addr == 6'h19 |=>
        reg_rd_data[7:6] == 2'h0) else $error("unused bits read nonzero");

    c_freeze: cover property (freq_loop_freeze);
    c_post: cover property (freq_loop_gain == 4'h1);
    c_read: cover property (reg_rd_en && reg_addr == 6'h1A);
endmodule : dlgc_loop_cfg_chk

bind dlgc_loop_cfg dlgc_loop_cfg_chk u_chk (.*);

// >>> tb_top.sv
// Self-checking bench for the demodulator loop gain register bank.
`timescale 1ns/1ps

module tb_top
    import dlgc_pkg::*;
;
    logic clk_sys = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0;
    logic rx_active = 0, carrier_sense = 0, sync_detected = 0, c;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wr_data = 8'h00, reg_rd_data, f, b;
    logic freq_loop_freeze, clk_loop_freeze;
    dlgc_gain_t freq_loop_gain, clk_integral_gain, clk_prop_gain;
    dlgc_sel_t freq_offset_saturation, rate_offset_saturation;
    int n_mismatch = 0, compares = 0;

    always #25 clk_sys = ~clk_sys;

    dlgc_loop_cfg uut (.*);

    // ==========================================================================
    // Expectations and checks
    // Gains are in half steps: pre-sync is 2(code+1), the proportional post value is base KP.
    function automatic logic [7:0] gain(logic [1:0] code, logic pb, logic post, logic kp);
        if (post && pb) return kp ? 8'h02 : 8'h01;
        return {5'h00, code, 1'b0} + 8'h02;
    endfunction : gain

    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic conclude;
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(logic [5:0] a, logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(posedge clk_sys);
        #1 cmp(reg_rd_data, exp);
    endtask : rd

    // Three edges cover the latency of a gain: one stage after an input change, two after a register write.
    task automatic outs(logic post);
        repeat (3) @(posedge clk_sys);
        #1 cmp(freq_loop_freeze, 1'b0);
        cmp(freq_loop_gain, gain(f[4:3], f[2], post, 1'b0));
        cmp(clk_integral_gain, gain(b[7:6], b[3], post, 1'b0));
        cmp(clk_prop_gain, gain(b[5:4], b[2], post, 1'b1));
        cmp(freq_offset_saturation, f[1:0]);
        cmp(rate_offset_saturation, b[1:0]);
    endtask : outs

    // ==========================================================================
    // Main sequence
    initial begin
        void'($urandom(65919));
        f = 8'h36;
        b = 8'h6C;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        rd(6'h19, 8'h36);
        rd(6'h1A, 8'h6C);
        outs(1'b0);
        for (int i = 0; i < 24; i++) begin
            // Pass 0 forces all-ones frequency fields with a zero limit as used with on-off keying; pass 1 forces an all-ones bit sync value.
            f = (i == 0) ? 8'hFC : 8'($urandom);
            b = (i == 1) ? 8'hFF : 8'($urandom);
            c = (i < 2) ? 1'b0 : 1'($urandom);
            wr(6'h19, f);
            wr(6'h1A, b);
            wr(6'h20 + 6'(i), 8'($urandom));
            rd(6'h20 + 6'(i), 8'h00);
            f = f & 8'h3F;
            rd(6'h19, f);
            rd(6'h1A, b);
            @(posedge clk_sys);
            rx_active <= 1'b1;
            carrier_sense <= c;
            repeat (3) @(posedge clk_sys);
            #1 cmp(freq_loop_freeze, f[5] & ~c);
            cmp(clk_loop_freeze, f[5] & ~c);
            @(posedge clk_sys);
            carrier_sense <= 1'b1;
            outs(1'b0);
            @(posedge clk_sys);
            sync_detected <= 1'b1;
            outs(1'b1);
            @(posedge clk_sys);
            rx_active <= 1'b0;
            sync_detected <= 1'b0;
            carrier_sense <= 1'b0;
            outs(1'b0);
        end
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end
endmodule : tb_top
